// ===== hdl/rtp_pkg.sv
package rtp_pkg;

  // mode register, laid out as the software sees it
  typedef struct packed {
    logic run;
    logic [2:0] rate;
    logic cks;
    logic aload;
    logic toggle;
    logic pwm;
  } rtp_mode_type;

  // source that drives the wave output pin
  typedef enum logic [1:0] {
    RTP_SRC_GPIO = 2'b00,
    RTP_SRC_TOGGLE = 2'b01,
    RTP_SRC_PWM = 2'b10
  } rtp_src_type;

  // interrupt status / mask layout
  typedef struct packed {
    logic pin;
    logic ovf;
  } rtp_irq_type;

endpackage : rtp_pkg

// ===== hdl/rtp_regs.svh
`ifndef RTP_REGS_SVH
`define RTP_REGS_SVH

// register indices; byte address is four times the index
`define RTP_IDX_MODE 8'hDC
`define RTP_IDX_COUNT 8'hDD
`define RTP_IDX_RELOAD 8'hDE
`define RTP_IDX_STATUS 8'hE0
`define RTP_IDX_MASK 8'hE1

// mode register field positions
`define RTP_BIT_PWM 0
`define RTP_BIT_TOGGLE 1
`define RTP_BIT_ALOAD 2
`define RTP_BIT_CKS 3
`define RTP_BIT_RATE_LO 4
`define RTP_BIT_RATE_HI 6
`define RTP_BIT_RUN 7

// status and mask bit positions
`define RTP_BIT_OVF 0
`define RTP_BIT_PIN 1

// reset values
`define RTP_RST_MODE 8'h00
`define RTP_RST_COUNT 8'h00
`define RTP_RST_RELOAD 8'h00
`define RTP_RST_IRQ 2'h0

// overflow boundary masks (top count of each boundary)
`define RTP_TOP_256 8'hFF
`define RTP_TOP_64 8'h3F
`define RTP_TOP_32 8'h1F
`define RTP_TOP_16 8'h0F

// prescaler: code 000 divides by 256
`define RTP_DIV_MASK 8'hFF

`endif

// ===== hdl/rtp_timer.sv
// Function
// R1: counter increments per tick; wraps at top, keeps counting, raises overflow request
// R2: clock source bit picks prescaled clock at 0, event pin at 1
// R3: external mode advances once per falling edge on event pin
// R4: rate code 000 divides by 256, each step halves, 111 divides by 2
// R5: external source ignores rate and keeps the pin's own flag at zero
// R6: run enable 0 stops counter, 1 lets it count
// R7: pwm enable drives pwm wave, range set by toggle and reload bits
// R8: pwm off and toggle on routes toggle signal to pin, else pin is I/O
// R9: pwm off, reload bit enables automatic reload
// R10: on overflow with reload active, active reload value loads counter
// R11: reload writes go to holding buffer, moved to active on overflow; code also moves it every clock while run is 0
// R12: pwm forces reload on; reload bit then selects boundary
// R13: boundary 256 unless pwm internal; then 00/01/10/11 give 256/64/32/16
// R14: software preloads count and reload with boundary minus interval counts
// R15: toggle output inverts on each overflow
// R16: pwm goes low at count equal reload, high at count zero; code also sets it high on each overflow
// R17: overflow flag stays set until software clears it; zero after reset
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rtp_regs.svh"

module rtp_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // event pin, asynchronous
  input wire logic event_input_pin,
  // port logic behind the wave pin
  input wire logic gpio_out,
  input wire logic gpio_oe,
  // wave pin
  output logic wave_output_pin_o,
  output logic wave_output_pin_oe,
  // interrupt
  output logic irq
);

  // ****************************************
  // helper functions
  // ****************************************
  function automatic logic [7:0] rtp_top(input rtp_pkg::rtp_mode_type m);
    logic [7:0] t;
    t = `RTP_TOP_256;
    if (m.pwm && !m.cks) begin
      unique case ({m.aload, m.toggle})
        2'b00: t = `RTP_TOP_256;
        2'b01: t = `RTP_TOP_64;
        2'b10: t = `RTP_TOP_32;
        2'b11: t = `RTP_TOP_16;
      endcase
    end
    return t;
  endfunction : rtp_top

  function automatic logic rtp_sel(input logic [9:0] a, input logic [7:0] i);
    return (a[9:2] == i) && (a[1:0] == 2'b00);
  endfunction : rtp_sel

  // ****************************************
  // register storage
  // ****************************************
  rtp_pkg::rtp_mode_type mode_q;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [7:0] hold_q;
  logic [7:0] active_q;
  rtp_pkg::rtp_irq_type status_q;
  rtp_pkg::rtp_irq_type status_d;
  rtp_pkg::rtp_irq_type mask_q;
  logic ack_q;
  logic [31:0] rdata_q;

  // ****************************************
  // bus decode
  // ****************************************
  // one wait state: the answer is ready on the second edge of a request
  wire req = avs_read | avs_write;
  wire wr_go = avs_write & ack_q & avs_byteenable[0];
  wire sel_mode = rtp_sel(avs_address, `RTP_IDX_MODE);
  wire sel_count = rtp_sel(avs_address, `RTP_IDX_COUNT);
  wire sel_reload = rtp_sel(avs_address, `RTP_IDX_RELOAD);
  wire sel_status = rtp_sel(avs_address, `RTP_IDX_STATUS);
  wire sel_mask = rtp_sel(avs_address, `RTP_IDX_MASK);
  wire [7:0] wbyte = avs_writedata[7:0];

  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata = rdata_q;

  // reload register is write only and unmapped addresses read zero
  wire [7:0] rd_mux = sel_mode ? mode_q :
                      sel_count ? count_q :
                      sel_status ? {6'h00, status_q} :
                      sel_mask ? {6'h00, mask_q} : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read && !ack_q) begin
        rdata_q <= {24'h000000, rd_mux};
      end
    end
  end

  // ****************************************
  // event pin synchroniser
  // ****************************************
  logic evt_s1_q;
  logic evt_s2_q;
  logic evt_s3_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_s1_q <= 1'b1;
      evt_s2_q <= 1'b1;
      evt_s3_q <= 1'b1;
    end else begin
      evt_s1_q <= event_input_pin;
      evt_s2_q <= evt_s1_q;
      evt_s3_q <= evt_s2_q;
    end
  end

  wire evt_fall = evt_s3_q & ~evt_s2_q;

  // ****************************************
  // prescaler
  // ****************************************
  // free running so that the divider phase does not depend on run enable
  logic [7:0] div_q;
  wire [7:0] div_mask = 8'(`RTP_DIV_MASK >> mode_q.rate);
  wire int_tick = (div_q & div_mask) == div_mask; // R4

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ****************************************
  // counter and reload
  // ****************************************
  wire tick = mode_q.cks ? evt_fall : int_tick; // R2 R3 R5
  wire step = mode_q.run & tick; // R6
  wire [7:0] top = rtp_top(mode_q); // R13
  wire at_top = (count_q & top) == top;
  wire ovf = step & at_top; // R1
  wire reload_on = mode_q.pwm | mode_q.aload; // R9 R12

  always_comb begin
    count_d = count_q;
    if (ovf) begin
      count_d = reload_on ? (active_q & top) : 8'h00; // R10
    end else if (step) begin
      count_d = (count_q + 8'h01) & top; // R1
    end
    if (wr_go && sel_count) begin
      count_d = wbyte;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= `RTP_RST_COUNT;
    end else begin
      count_q <= count_d;
    end
  end

  // while stopped the held value passes straight through, so a fresh
  // setup takes effect without waiting for a first overflow
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_q <= `RTP_RST_RELOAD;
      active_q <= `RTP_RST_RELOAD;
    end else begin
      if (wr_go && sel_reload) begin
        hold_q <= wbyte; // R11
      end
      if (ovf || !mode_q.run) begin
        active_q <= hold_q; // R11
      end
    end
  end

  // ****************************************
  // mode register
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= `RTP_RST_MODE;
    end else if (wr_go && sel_mode) begin
      mode_q <= wbyte;
    end
  end

  // ****************************************
  // wave outputs
  // ****************************************
  logic tog_q;
  logic pwm_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tog_q <= 1'b0;
    end else if (ovf) begin
      tog_q <= ~tog_q; // R15
    end
  end

  // equal-to-reload wins over zero, so a reload of zero keeps the output low except for one clock after each overflow
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_q <= 1'b0;
    end else if (!mode_q.run) begin
      pwm_q <= 1'b0;
    end else if (count_q == (active_q & top)) begin
      pwm_q <= 1'b0; // R16
    end else if (count_q == 8'h00 || ovf) begin
      // a reloaded counter never passes zero, so the wrap stands for it
      pwm_q <= 1'b1; // R16
    end
  end

  rtp_pkg::rtp_src_type src;
  assign src = mode_q.pwm ? rtp_pkg::RTP_SRC_PWM : // R7
               mode_q.toggle ? rtp_pkg::RTP_SRC_TOGGLE : // R8
               rtp_pkg::RTP_SRC_GPIO;

  always_comb begin
    unique case (src)
      rtp_pkg::RTP_SRC_PWM: begin
        wave_output_pin_o = pwm_q;
        wave_output_pin_oe = 1'b1;
      end
      rtp_pkg::RTP_SRC_TOGGLE: begin
        wave_output_pin_o = tog_q;
        wave_output_pin_oe = 1'b1;
      end
      default: begin
        wave_output_pin_o = gpio_out;
        wave_output_pin_oe = gpio_oe;
      end
    endcase
  end

  // ****************************************
  // interrupt status and mask
  // ****************************************
  // a set in the same cycle as a write-one clear wins over the clear
  always_comb begin
    status_d = status_q;
    if (wr_go && sel_status) begin
      status_d = status_q & ~rtp_pkg::rtp_irq_type'(wbyte[1:0]);
    end
    if (ovf) begin
      status_d.ovf = 1'b1; // R1 R17
    end
    if (evt_fall && !mode_q.cks) begin
      status_d.pin = 1'b1;
    end
    if (mode_q.cks) begin
      status_d.pin = 1'b0; // R5
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= `RTP_RST_IRQ;
      mask_q <= `RTP_RST_IRQ;
    end else begin
      status_q <= status_d;
      if (wr_go && sel_mask) begin
        mask_q <= wbyte[1:0];
      end
    end
  end

  assign irq = |(status_q & mask_q);

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_overflow_sets_flag: assert property ( // R1
    ovf |=> status_q.ovf)
    else $error("overflow did not set the flag");
  a_count_increments: assert property ( // R1
    step && !at_top && !(wr_go && sel_count)
    |=> count_q == (($past(count_q) + 8'h01) & $past(top)))
    else $error("counter did not step by one");
  a_stopped_holds: assert property ( // R6
    !mode_q.run && !(wr_go && sel_count) |=> $stable(count_q))
    else $error("stopped counter moved");
  a_ext_pin_flag: assert property ( // R5
    mode_q.cks |=> !status_q.pin)
    else $error("pin flag set in external mode");
  a_reload_on_ovf: assert property ( // R10
    ovf && reload_on && !(wr_go && sel_count)
    |=> count_q == $past(active_q & top))
    else $error("reload not copied on overflow");
  a_no_reload_zero: assert property ( // R9
    ovf && !reload_on && !(wr_go && sel_count) |=> count_q == 8'h00)
    else $error("counter not cleared on plain overflow");
  a_hold_waits_ovf: assert property ( // R11
    mode_q.run && !ovf |=> $stable(active_q))
    else $error("active reload changed without overflow");
  a_toggle_flips: assert property ( // R15
    ovf |=> tog_q != $past(tog_q))
    else $error("toggle did not invert");
  a_toggle_route: assert property ( // R8
    !mode_q.pwm && mode_q.toggle
    |-> wave_output_pin_oe && wave_output_pin_o == tog_q)
    else $error("toggle not on the pin");
  a_pwm_low_match: assert property ( // R16
    mode_q.run && count_q == (active_q & top) |=> !pwm_q)
    else $error("pwm not low at match");
  a_boundary_16: assert property ( // R13
    mode_q.pwm && !mode_q.cks && mode_q.aload && mode_q.toggle
    |-> top == 8'h0F)
    else $error("wrong pwm boundary");
  a_flag_sticky: assert property ( // R17
    status_q.ovf && !(wr_go && sel_status) |=> status_q.ovf)
    else $error("flag dropped without clear");

  c_pwm_cycle: cover property (mode_q.pwm && ovf ##[1:300] ovf);
  c_ext_count: cover property (mode_q.cks && step);
  c_set_and_clear: cover property (ovf && wr_go && sel_status);
  c_irq_raise: cover property (!irq ##1 irq);

endmodule : rtp_timer

`default_nettype wire

// ===== tb/rtp_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// far side: event source and wave pin load
// ****************************************
module rtp_pin_model (
  // clock
  input wire logic clk,
  // wave pin as driven by the timer
  input wire logic wave_o,
  input wire logic wave_oe,
  // resolved pin levels
  output logic event_pin,
  output logic wave_pin
);
  // the pin has a pull-up, so a released pin reads high
  assign wave_pin = wave_oe ? wave_o : 1'b1;
  initial event_pin = 1'b1;
  // phases outlast the three-flop synchroniser so no edge is lost
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      event_pin <= 1'b0;
      repeat (4) @(posedge clk);
      event_pin <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask : pulses
endmodule : rtp_pin_model
`default_nettype wire

// ===== tb/rtp_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rtp_timer_tb;
  localparam logic [9:0] AM = 10'h370;
  localparam logic [9:0] AC = 10'h374;
  localparam logic [9:0] AR = 10'h378;
  localparam logic [9:0] AS = 10'h380;
  localparam logic [9:0] AK = 10'h384;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic gpio_out = 1'b0;
  logic gpio_oe = 1'b0;
  logic wo, woe, irq, ev, pin;
  logic [15:0] c, t1, t2;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  rtp_timer dut_u (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .event_input_pin(ev), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .wave_output_pin_o(wo), .wave_output_pin_oe(woe), .irq(irq));
  rtp_pin_model ev_u (.clk(clk), .wave_o(wo), .wave_oe(woe),
    .event_pin(ev), .wave_pin(pin));
  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  // one wait state is normal; the bound only catches a hung slave
  task automatic bus(input logic w, input logic [9:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= ~w;
    avs_write <= w;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 100);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 100) cmp(16'h0, 16'h1);
  endtask : bus
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic chk(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    cmp({8'h00, q}, {8'h00, e});
  endtask : chk
  task automatic wchg(output logic [15:0] n);
    logic v;
    v = pin;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pin === v && n < 2000);
  endtask : wchg
  task automatic wirq(output logic [15:0] t);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    t = 16'(cyc);
  endtask : wirq
  task automatic final_report;
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial begin
    #200000;
    err_total++;
    final_report();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    chk(AM, 8'h00);
    chk(AC, 8'h00);
    chk(AR, 8'h00);
    chk(AS, 8'h00);
    chk(10'h3FC, 8'h00);
    // every rate code; reload FE gives an overflow each second tick
    for (int r = 0; r < 8; r++) begin
      wr(AM, 8'h00);
      wr(AR, 8'hFE);
      wr(AC, 8'hFE);
      wr(AM, {1'b1, 3'(r), 4'b0110});
      // first toggle comes at an unknown divider phase; measure a later one
      wchg(c);
      wchg(c);
      wchg(c);
      cmp(c, 16'(512 >> r));
      cmp({15'h0, woe}, 16'h1);
    end
    // pin handed back to port logic
    wr(AM, 8'h00);
    gpio_out <= 1'b1;
    gpio_oe <= 1'b1;
    @(negedge clk);
    cmp({14'h0, wo, woe}, 16'h3);
    gpio_out <= 1'b0;
    @(negedge clk);
    cmp({14'h0, wo, woe}, 16'h1);
    // event counting; a fast rate is set to show it is ignored
    wr(AS, 8'h03);
    wr(AK, 8'h01);
    wr(AC, 8'hFE);
    wr(AM, 8'hF8);
    ev_u.pulses(3);
    repeat (8) @(posedge clk);
    wr(AM, 8'h78);
    ev_u.pulses(2);
    chk(AC, 8'h01);
    chk(AS, 8'h01);
    @(negedge clk);
    cmp({15'h0, irq}, 16'h1);
    wr(AK, 8'h00);
    @(negedge clk);
    cmp({15'h0, irq}, 16'h0);
    wr(AK, 8'h01);
    wr(AS, 8'h01);
    chk(AS, 8'h00);
    @(negedge clk);
    cmp({15'h0, irq}, 16'h0);
    // pwm for each boundary pair, reload 4, counter started at zero
    for (int p = 0; p < 4; p++) begin
      wr(AM, 8'h00);
      wr(AS, 8'h01);
      wr(AR, 8'h04);
      wr(AC, 8'h00);
      wr(AM, {5'b11110, 2'(p), 1'b1});
      wchg(c);
      wchg(c);
      cmp(16'(c >= 7 && c <= 8), 16'h1);
      cmp({15'h0, woe}, 16'h1);
      wirq(t1);
      wr(AS, 8'h01);
      @(posedge clk);
      wirq(t2);
      cmp(t2 - t1, 16'(((p == 0) ? 256 : (128 >> p)) * 2 - 8));
    end
    wr(AM, 8'h00);
    final_report();
  end
endmodule : rtp_timer_tb
`default_nettype wire
